// ==== logic/srw_pkg.sv ====
// Constants, types and selection helpers for the supervisor reset watchdog.
// Assumes a 40 MHz system clock and a 32-bit APB register port.
package srw_pkg;

  localparam int          CLK_HZ        = 40_000_000;
  localparam int          OSC_HZ        = 10_240;
  localparam int          OSC_DIV       = CLK_HZ / OSC_HZ;
  localparam int          DIV_W         = 12;

  localparam int          T_WD_SHORT_MS = 100;
  localparam int          T_WD_LONG_MS  = 1600;
  localparam int          T_RST_STD_MS  = 50;
  localparam int          T_RST_LONG_MS = 200;

  localparam int          CNT_W         = 16;
  localparam logic [15:0] INT_WD_SHORT  = 16'(T_WD_SHORT_MS * OSC_HZ / 1000);
  localparam logic [15:0] INT_WD_LONG   = 16'(T_WD_LONG_MS * OSC_HZ / 1000);
  localparam logic [15:0] INT_RST_STD   = 16'(T_RST_STD_MS * OSC_HZ / 1000);
  localparam logic [15:0] INT_RST_LONG  = 16'(T_RST_LONG_MS * OSC_HZ / 1000);
  localparam logic [15:0] EXT_WD_NORM   = 16'h0400;
  localparam logic [15:0] EXT_WD_POST   = 16'h1000;
  localparam logic [15:0] EXT_RST_STD   = 16'h0200;
  localparam logic [15:0] EXT_RST_LONG  = 16'h0800;
  localparam logic [15:0] CNT_ONE       = 16'h0001;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;

  // Synchroniser lanes
  localparam int          SYNC_W        = 5;
  localparam int          SY_SUPPLY     = 0;
  localparam int          SY_TOGGLE     = 1;
  localparam int          SY_FLOAT      = 2;
  localparam int          SY_PERIOD     = 3;
  localparam int          SY_SEL        = 4;

  // APB map
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_WD_CNT   = 12'h008;
  localparam logic [11:0] ADDR_RST_CNT  = 12'h00C;
  localparam int          CTRL_LONG_BIT = 0;
  localparam int          CTRL_FIX_BIT  = 1;
  localparam int          ST_FLAG_BIT   = 3;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;

  typedef struct packed {
    logic fixed_cfg;
    logic long_pulse;
  } srw_ctrl_t;

  typedef struct packed {
    logic internal_osc;
    logic wd_flag;
    logic long_mode;
    logic wdo_n;
    logic rst_active;
  } srw_status_t;

  typedef enum logic [0:0] {ST_HOLD, ST_RUN} srw_state_t;

  // Watchdog timeout in timing ticks
  function automatic logic [15:0] srw_timeout(input srw_ctrl_t c, input logic ext_clk,
                                              input logic period_hi, input logic long_mode);
    if (c.fixed_cfg)
      return INT_WD_LONG;
    else if (ext_clk)
      return long_mode ? EXT_WD_POST : EXT_WD_NORM;
    else if (long_mode || period_hi)
      return INT_WD_LONG;
    else
      return INT_WD_SHORT;
  endfunction

  // Reset active period in timing ticks
  function automatic logic [15:0] srw_reset_len(input srw_ctrl_t c, input logic ext_clk);
    if (ext_clk && !c.fixed_cfg)
      return c.long_pulse ? EXT_RST_LONG : EXT_RST_STD;
    else
      return c.long_pulse ? INT_RST_LONG : INT_RST_STD;
  endfunction

endpackage

// ==== logic/srw_tick_gen.sv ====
// Timing tick source: internal oscillator prescaler or external clock edges.
// Assumes the external level arrives already synchronised.
module srw_tick_gen
  import srw_pkg::*;
#(
  parameter int DIV = OSC_DIV
) (
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  input  wire logic use_ext_in,
  input  wire logic ext_level_in,
  output logic      tick_out
);

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ONE  = DIV_W'(1);

  logic [DIV_W-1:0] div_r;
  logic             ext_prev_r;
  logic             tick_r;

  wire logic        div_wrap = (div_r == DIV_LAST);
  wire logic        ext_rise = ext_level_in & ~ext_prev_r;
  // Internal tick at the oscillator rate; prescaler held so switching back starts clean
  wire logic        tick_nxt = use_ext_in ? ext_rise : div_wrap;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || use_ext_in || div_wrap) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_ONE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ext_prev_r <= 1'b0;
      tick_r     <= 1'b0;
    end else begin
      ext_prev_r <= ext_level_in;
      tick_r     <= tick_nxt;
    end
  end

  assign tick_out = tick_r;

endmodule

// ==== logic/srw_top.sv ====
// Supervisor reset generator and watchdog with APB control and status.
// Assumes the supply comparator and midsupply detector are digital inputs.
//
// Decided for this implementation: the APB slave port and the register addresses.
module srw_top
  import srw_pkg::*;
#(
  parameter int OSC_DIV_P = OSC_DIV
) (
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  input  wire logic              supply_ok_in,
  input  wire logic              watchdog_toggle_input_in,
  input  wire logic              watchdog_toggle_float_in,
  input  wire logic              clock_source_select_in,
  input  wire logic              clock_or_period_input_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic                   reset_n_out,
  output logic                   reset_out,
  output logic                   watchdog_expired_n_out
);

  // Input synchronisers
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic              toggle_prev_r;

  wire logic [SYNC_W-1:0] raw_in = {clock_source_select_in, clock_or_period_input_in,
                                    watchdog_toggle_float_in, watchdog_toggle_input_in,
                                    supply_ok_in};

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sync1_r       <= '0;
      sync2_r       <= '0;
      toggle_prev_r <= 1'b0;
    end else begin
      sync1_r       <= raw_in;
      sync2_r       <= sync1_r;
      toggle_prev_r <= sync2_r[SY_TOGGLE];
    end
  end

  wire logic supply_low  = ~sync2_r[SY_SUPPLY];
  wire logic wd_float    = sync2_r[SY_FLOAT];
  wire logic ext_clk     = ~sync2_r[SY_SEL];
  wire logic period_hi   = sync2_r[SY_PERIOD];
  // Floating input cannot produce a valid edge
  wire logic toggle_edge = (sync2_r[SY_TOGGLE] ^ toggle_prev_r) & ~wd_float;

  // Timing tick
  logic tick;

  srw_tick_gen #(
    .DIV (OSC_DIV_P)
  ) u_tick (
    .ref_clk_in   (ref_clk_in),
    .reset_in     (reset_in),
    .use_ext_in   (ext_clk),
    .ext_level_in (period_hi),
    .tick_out     (tick)
  );

  // Control register and state
  srw_ctrl_t   ctrl_r;
  srw_state_t  state_r;
  logic [15:0] rst_cnt_r;
  logic [15:0] wd_cnt_r;
  logic        long_mode_r;
  logic        wdo_n_r;
  logic        rst_n_r;
  logic        rst_r;
  logic        wd_flag_r;

  wire logic [15:0] timeout   = srw_timeout(ctrl_r, ext_clk, period_hi, long_mode_r);
  wire logic [15:0] reset_len = srw_reset_len(ctrl_r, ext_clk);

  wire logic hold_done = (state_r == ST_HOLD) & tick & ~supply_low
                         & (rst_cnt_r + CNT_ONE >= reset_len);
  wire logic run_tick  = (state_r == ST_RUN) & tick & ~wd_float & ~toggle_edge;
  // Expiry only while the input is actively driven
  wire logic expire    = run_tick & ~supply_low
                         & (wd_cnt_r + CNT_ONE >= timeout);

  srw_state_t  state_nxt;
  logic [15:0] rst_cnt_nxt;
  logic [15:0] wd_cnt_nxt;
  logic        long_mode_nxt;
  logic        wdo_n_nxt;

  always_comb begin
    state_nxt     = state_r;
    rst_cnt_nxt   = rst_cnt_r;
    wd_cnt_nxt    = wd_cnt_r;
    long_mode_nxt = long_mode_r;
    wdo_n_nxt     = wdo_n_r;
    if (toggle_edge) begin
      wdo_n_nxt = 1'b1;
    end
    case (state_r)
      ST_HOLD: begin
        wd_cnt_nxt    = CNT_ZERO;
        long_mode_nxt = 1'b1;
        if (supply_low) begin
          rst_cnt_nxt = CNT_ZERO;
        end else if (hold_done) begin
          state_nxt   = ST_RUN;
          rst_cnt_nxt = CNT_ZERO;
        end else if (tick) begin
          rst_cnt_nxt = rst_cnt_r + CNT_ONE;
        end
      end
      ST_RUN: begin
        if (supply_low) begin
          state_nxt   = ST_HOLD;
          rst_cnt_nxt = CNT_ZERO;
        end else if (toggle_edge || wd_float) begin
          wd_cnt_nxt = CNT_ZERO;
          if (toggle_edge) begin
            long_mode_nxt = 1'b0;
          end
        end else if (expire) begin
          state_nxt   = ST_HOLD;
          rst_cnt_nxt = CNT_ZERO;
          wd_cnt_nxt  = CNT_ZERO;
          wdo_n_nxt   = 1'b0;
        end else if (run_tick) begin
          wd_cnt_nxt = wd_cnt_r + CNT_ONE;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
    if (supply_low) begin
      wdo_n_nxt = 1'b1;
    end
  end

  // Both reset pins come from one decision so they never disagree
  wire logic rst_assert_nxt = (state_nxt == ST_HOLD);

  // APB slave: one wait state, data and response registered
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  wire logic        access    = psel_in & penable_in & ~pready_r;
  wire logic        commit    = psel_in & penable_in & pready_r;
  wire logic        hit_ctrl  = (paddr_in == ADDR_CTRL);
  wire logic        hit_stat  = (paddr_in == ADDR_STATUS);
  wire logic        hit_wd    = (paddr_in == ADDR_WD_CNT);
  wire logic        hit_rst   = (paddr_in == ADDR_RST_CNT);
  wire logic        mapped    = hit_ctrl | hit_stat | hit_wd | hit_rst;
  wire logic        wr_ctrl   = commit & pwrite_in & hit_ctrl;
  wire logic        clr_flag  = commit & pwrite_in & hit_stat & pwdata_in[ST_FLAG_BIT];
  wire srw_status_t status    = '{internal_osc: ~ext_clk, wd_flag: wd_flag_r,
                                  long_mode: long_mode_r, wdo_n: wdo_n_r, rst_active: rst_r};
  wire logic [31:0] rd_mux    = hit_ctrl ? 32'(ctrl_r) :
                                hit_stat ? 32'(status) :
                                hit_wd   ? 32'(wd_cnt_r) :
                                hit_rst  ? 32'(rst_cnt_r) : 32'h0000_0000;
  // A new expiry beats a simultaneous software clear
  wire logic        flag_nxt  = expire | (wd_flag_r & ~clr_flag);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      ctrl_r    <= CTRL_RESET;
    end else begin
      pready_r  <= access;
      pslverr_r <= access & ~mapped;
      prdata_r  <= (access & ~pwrite_in) ? rd_mux : 32'h0000_0000;
      if (wr_ctrl) begin
        ctrl_r <= srw_ctrl_t'({pwdata_in[CTRL_FIX_BIT], pwdata_in[CTRL_LONG_BIT]});
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_r     <= ST_HOLD;
      rst_cnt_r   <= CNT_ZERO;
      wd_cnt_r    <= CNT_ZERO;
      long_mode_r <= 1'b1;
      wdo_n_r     <= 1'b1;
      rst_n_r     <= 1'b0;
      rst_r       <= 1'b1;
      wd_flag_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      rst_cnt_r   <= rst_cnt_nxt;
      wd_cnt_r    <= wd_cnt_nxt;
      long_mode_r <= long_mode_nxt;
      wdo_n_r     <= wdo_n_nxt;
      rst_n_r     <= ~rst_assert_nxt;
      rst_r       <= rst_assert_nxt;
      wd_flag_r   <= flag_nxt;
    end
  end

  assign prdata_out             = prdata_r;
  assign pready_out             = pready_r;
  assign pslverr_out            = pslverr_r;
  assign reset_n_out            = rst_n_r;
  assign reset_out              = rst_r;
  assign watchdog_expired_n_out = wdo_n_r;

  // Checks
  a_reset_pair_compl: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    reset_out == ~reset_n_out)
    else $error("reset outputs not complementary");

  a_low_supply_reset: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    supply_low |=> !reset_n_out && reset_out)
    else $error("reset not asserted on low supply");

  a_wdo_low_supply: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    supply_low |=> watchdog_expired_n_out)
    else $error("expired status not high on low supply");

  a_expiry_resets: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    expire |=> !reset_n_out && !watchdog_expired_n_out && state_r == ST_HOLD)
    else $error("expiry did not reset");

  a_float_disables: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (state_r == ST_RUN && wd_float && !supply_low) |=> wd_cnt_r == CNT_ZERO && reset_n_out)
    else $error("watchdog ran while input floating");

  a_toggle_restarts: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (state_r == ST_RUN && toggle_edge && !supply_low) |=> wd_cnt_r == CNT_ZERO && !long_mode_r)
    else $error("toggle did not restart timeout");

  a_reset_end_long: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    hold_done |=> state_r == ST_RUN && long_mode_r && wd_cnt_r == CNT_ZERO && reset_n_out)
    else $error("reset end did not restart long timeout");

  a_wdo_held_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (!watchdog_expired_n_out && !toggle_edge && !supply_low) |=> !watchdog_expired_n_out)
    else $error("expired status released without toggle");

  a_hold_pulse_len: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (state_r == ST_HOLD && rst_cnt_r + CNT_ONE < reset_len) |=> state_r == ST_HOLD)
    else $error("reset pulse ended early");

  a_apb_one_wait: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (psel_in && penable_in && !pready_out) |=> pready_out)
    else $error("APB answer late");

  a_apb_ready_pulse: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    pready_out |=> !pready_out)
    else $error("APB ready longer than one cycle");

  a_apb_err_unmapped: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (psel_in && penable_in && !pready_out && !mapped) |=> pslverr_out)
    else $error("APB error missing on unmapped address");

  a_apb_rdata_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !pready_out |-> prdata_out == 32'h0000_0000)
    else $error("APB read data not zero outside answer");

  a_ctrl_write_lands: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wr_ctrl |=> ctrl_r.long_pulse == $past(pwdata_in[CTRL_LONG_BIT])
                && ctrl_r.fixed_cfg == $past(pwdata_in[CTRL_FIX_BIT]))
    else $error("control write lost");

  a_flag_set_expiry: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    expire |=> wd_flag_r)
    else $error("expiry flag not set");

  a_flag_clear_works: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (clr_flag && !expire) |=> !wd_flag_r)
    else $error("expiry flag not cleared");

  a_low_supply_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    supply_low |=> state_r == ST_HOLD && rst_cnt_r == CNT_ZERO)
    else $error("reset period not restarted on low supply");

  a_hold_keeps_long: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    state_r == ST_HOLD |=> long_mode_r)
    else $error("long timeout not armed during reset");

  a_run_count_step: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (state_r == ST_RUN && run_tick && !expire && !supply_low) |=> wd_cnt_r == $past(wd_cnt_r) + CNT_ONE)
    else $error("watchdog count did not advance");

  a_run_count_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (state_r == ST_RUN && !tick && !toggle_edge && !wd_float && !supply_low) |=> $stable(wd_cnt_r))
    else $error("watchdog count moved without tick");

  a_hold_count_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (state_r == ST_HOLD && !tick && !supply_low) |=> $stable(rst_cnt_r) && state_r == ST_HOLD)
    else $error("reset count moved without tick");

  a_wdo_rise_cause: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $rose(watchdog_expired_n_out) |-> $past(toggle_edge) || $past(supply_low))
    else $error("expired status released without cause");

  a_wdo_fall_cause: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $fell(watchdog_expired_n_out) |-> $past(expire))
    else $error("expired status low without expiry");

  a_long_leaves_kick: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $fell(long_mode_r) |-> $past(toggle_edge))
    else $error("long timeout left without toggle");

endmodule

// ==== tb/srw_cpu_model.sv ====
// Processor model on the far side of the watchdog toggle line.
// Assumes the supervisor clock; gap_in is counted in those clock cycles.
module srw_cpu_model (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        run_in,
  input  wire logic [31:0] gap_in,
  output logic             toggle_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt_r;
  initial begin
    toggle_out = 1'b0;
    cnt_r = 32'h0;
  end
  // Line keeps its current level while held in reset or idle
  always @(posedge ref_clk_in) begin
    if (!reset_n_in || !run_in) begin
      cnt_r <= 32'h0;
    end else if (cnt_r >= gap_in) begin
      cnt_r <= 32'h0;
      toggle_out <= ~toggle_out;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the supervisor reset watchdog.
// Assumes a shortened prescaler and an external timing clock made here.
module tb
  import srw_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;
  localparam int HALF = 3;
  logic              clk, rst, sup, flt, sel, osc, psel, pen, pwr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, gap, rd;
  logic              pready, pslverr, rst_n, rst_hi, expired_n, tog, run, se;
  int                err_count, check_count, cyc, ticks, last_kick, t0, osc_cnt, n_rst;

  srw_top #(.OSC_DIV_P(DIV)) i_srw_top (
    .ref_clk_in(clk), .reset_in(rst), .supply_ok_in(sup), .watchdog_toggle_input_in(tog),
    .watchdog_toggle_float_in(flt), .clock_source_select_in(sel), .clock_or_period_input_in(osc),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .reset_n_out(rst_n),
    .reset_out(rst_hi), .watchdog_expired_n_out(expired_n));
  srw_cpu_model i_srw_cpu_model (
    .ref_clk_in(clk), .reset_n_in(rst_n), .run_in(run), .gap_in(gap), .toggle_out(tog));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // External timing clock runs only in external mode; one tick per rising edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!sel) begin
      osc_cnt <= (osc_cnt == HALF - 1) ? 0 : osc_cnt + 1;
      if (osc_cnt == HALF - 1) begin
        osc <= ~osc;
        if (!osc) ticks <= ticks + 1;
      end
    end
  end
  always @(tog) last_kick = ticks;
  always @(negedge rst_n) n_rst++;

  task automatic stop_test;
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ok(input string name, input logic c);
    check(name, {31'h0, c}, 32'h1);
  endtask
  function automatic logic near(input int seen, input int exp);
    return (seen >= exp - 2) && (seen <= exp + 3);
  endfunction
  task automatic wait_rst(input logic lvl);
    int n;
    n = 0;
    while (rst_n !== lvl && n < 60000) begin
      @(negedge clk);
      n++;
    end
    ok("reset wait", rst_n === lvl);
  endtask
  task automatic wait_kick;
    logic old;
    int n;
    old = tog;
    n = 0;
    while (tog === old && n < 60000) begin
      @(negedge clk);
      n++;
    end
    ok("kick seen", tog !== old);
  endtask
  // Request held from setup until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    ok("apb ready", pready === 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  initial begin
    void'($urandom(35));
    {rst, sup, flt, sel, osc, psel, pen, pwr, run} = 9'h100;
    {paddr, pwdata, gap} = '0;
    {err_count, check_count, cyc, ticks, osc_cnt, n_rst, last_kick} = '0;
    sel = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(negedge clk);
    ok("reset while supply low", rst_n === 1'b0 && rst_hi === 1'b1);
    @(posedge clk);
    sup <= 1'b1;
    t0 = cyc;
    wait_rst(1'b1);
    ok("internal reset length", (cyc - t0 >= 512 * DIV - 2) && (cyc - t0 <= 512 * DIV + 8));
    @(posedge clk);
    sel <= 1'b0;
    @(posedge clk);
    sup <= 1'b0;
    repeat (4) @(negedge clk);
    ok("supply low outputs", rst_n === 1'b0 && rst_hi === 1'b1 && expired_n === 1'b1);
    @(posedge clk);
    sup <= 1'b1;
    t0 = ticks;
    wait_rst(1'b1);
    ok("external reset length", near(ticks - t0, 512));
    t0 = ticks;
    wait_rst(1'b0);
    ok("post reset timeout", near(ticks - t0, 4096));
    ok("expiry outputs", expired_n === 1'b0 && rst_hi === 1'b1);
    t0 = ticks;
    wait_rst(1'b1);
    ok("watchdog pulse length", near(ticks - t0, 512));
    ok("expired holds", expired_n === 1'b0);
    t0 = n_rst;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      run <= 1'b1;
      gap <= 32'((i == 3 ? 1000 : $urandom % 700 + 200) * 2 * HALF);
      wait_kick;
      repeat (4) @(negedge clk);
      if (i == 0) ok("toggle restores expired", expired_n === 1'b1);
    end
    ok("kicks keep alive", n_rst == t0 && rst_n === 1'b1);
    @(posedge clk);
    run <= 1'b0;
    wait_rst(1'b0);
    ok("normal timeout", near(ticks - last_kick, 1024));
    apb(1'b0, ADDR_STATUS, 32'h0, rd, se);
    check("status after expiry", rd, 32'h0000_000D);
    apb(1'b1, ADDR_STATUS, 32'h0000_0008, rd, se);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, se);
    check("status flag cleared", rd, 32'h0000_0005);
    apb(1'b0, ADDR_WD_CNT, 32'h0, rd, se);
    check("count held in reset", rd, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, se);
    check("ctrl reset value", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0, rd, se);
    ok("unmapped access", se === 1'b1 && rd === 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1, rd, se);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, se);
    check("ctrl readback", rd, 32'h1);
    @(posedge clk);
    sup <= 1'b0;
    repeat (4) @(negedge clk);
    ok("supply low clears expired", expired_n === 1'b1 && rst_n === 1'b0);
    @(posedge clk);
    sup <= 1'b1;
    t0 = ticks;
    wait_rst(1'b1);
    ok("long pulse length", near(ticks - t0, 2048));
    @(posedge clk);
    run <= 1'b1;
    gap <= 32'(100 * 2 * HALF);
    wait_kick;
    @(posedge clk);
    run <= 1'b0;
    flt <= 1'b1;
    t0 = n_rst;
    repeat (1300 * 2 * HALF) @(negedge clk);
    ok("floating disables", n_rst == t0 && rst_n === 1'b1 && expired_n === 1'b1);
    stop_test;
  end
  // Whole sequence needs about 90000 cycles at the longest random gaps
  initial begin
    repeat (98000) @(posedge clk);
    err_count++;
    stop_test;
  end
endmodule
